// ---- eew_map.svh ----
// Register map, field positions and timing counts of the EEPROM write control
`ifndef EEW_MAP_SVH
`define EEW_MAP_SVH

// AXI address width and word index width
`define EEW_ADDR_W          12
`define EEW_IDX_W           10
// Word indices; byte address is four times the index
`define EEW_IDX_ARRAY_LAST  10'h07F
`define EEW_IDX_CONTROL     10'h0EA
`define EEW_IDX_IRQ_STATUS  10'h100
`define EEW_IDX_IRQ_MASK    10'h101

// Control register fields
`define EEW_BIT_STANDBY     6
`define EEW_BIT_START       3
`define EEW_BIT_ROW_MODE    2
`define EEW_BIT_BUSY        1
`define EEW_BIT_ENABLE      0
`define EEW_CTRL_RESET      8'h00

// Interrupt status and mask fields
`define EEW_IRQ_W           2
`define EEW_IRQ_DONE        0
`define EEW_IRQ_ABORT       1
`define EEW_IRQ_RESET       2'h0

// Array geometry and contents
`define EEW_ARRAY_BYTES     128
`define EEW_ROW_BYTES       8
`define EEW_ERASED_BYTE     8'hFF
`define EEW_LATCH_CLEAR     8'h00

// Programming cycle length in aclk cycles (4 ns each)
`define EEW_PROG_CYCLES_DEF 1000
`define EEW_TMR_W           20

// AXI responses
`define EEW_RESP_OKAY       2'h0
`define EEW_RESP_SLVERR     2'h2

`endif

// ---- eew_pkg.sv ----
// Types shared by the EEPROM write control modules
package eew_pkg;

  // What the running programming cycle will commit when it ends
  typedef enum logic [1:0] {
    EEW_IDLE,
    EEW_PROG_BYTE,
    EEW_PROG_ROW
  } eew_prog_e;

  typedef logic [7:0] eew_byte_t;
  typedef logic [4:0] eew_row_t;

endpackage : eew_pkg

// ---- eew_prog_timer.sv ----
// Programming cycle timer: busy for a fixed number of cycles, then a done pulse
`timescale 1ns/100ps
`include "eew_map.svh"
module eew_prog_timer import eew_pkg::*; #(
  parameter int CYCLES = `EEW_PROG_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control
  input  wire logic start,
  // Status
  output logic      busy,
  output logic      done
);

  localparam logic [`EEW_TMR_W-1:0] LOAD = `EEW_TMR_W'(CYCLES - 1);

  logic [`EEW_TMR_W-1:0] cnt_r;

  // Count down from the load value; a start while running is ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        cnt_r <= LOAD;
        busy  <= 1'b1;
      end else if (busy) begin
        if (cnt_r == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end

endmodule : eew_prog_timer

// ---- eew_write_ctrl.sv ----
// EEPROM array with byte and row write control behind an AXI4-Lite slave
// How it works
// - Standby bit 6 disables the array, aborts accesses, drops array power.
// - Start bit 3 in row mode launches one cycle programming the row.
// - Start bit clears itself when the launched programming cycle ends.
// - Only loaded row bytes are programmed; unloaded ones keep their contents.
// - Row mode set, start clear: array writes fill row latches instead.
// - Row is address bits 7..3; bits 2..0 pick the byte within it.
// - Row mode bit clears itself at the end of every row cycle.
// - Clearing row mode before start discards the loaded row untouched.
// - Busy bit 1 reads high while a programming cycle runs.
// - Array accesses while busy are aborted; running cycle completes.
// - Enable bit 0 must be set; no write cycle starts while low.
// - Control register writes are ignored while busy; only busy reads.
// - Start is taken only when enable and row mode are already set.
// - Setting row mode clears all eight row latches.
// - First row-mode write latches the row until cycle end or mode clear.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/100ps
`include "eew_map.svh"
module eew_write_ctrl import eew_pkg::*; #(
  parameter int PROG_CYCLES = `EEW_PROG_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write address
  input  wire logic [`EEW_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [`EEW_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Status to the rest of the chip
  output logic                       array_low_power,
  output logic                       program_in_progress,
  output logic                       irq
);

  // Control register state; a literal cannot be bit-selected, a constant can
  localparam logic [7:0] CTRL_RESET = `EEW_CTRL_RESET;
  logic       array_standby_r, program_enable_r;
  logic       row_mode_enable_r, row_program_start_r;
  // Programming sequence
  eew_prog_e  prog_state_r;
  logic       busy, tmr_start, tmr_busy, tmr_done;
  eew_byte_t  byte_addr_r, byte_data_r;
  // Row latches
  eew_row_t   row_addr_r;
  logic       row_addr_valid_r;
  logic [`EEW_ROW_BYTES-1:0] row_loaded_r;
  eew_byte_t  row_data_r [`EEW_ROW_BYTES];
  // Array cells start erased; nonvolatile, so reset leaves them alone
  eew_byte_t  cells [`EEW_ARRAY_BYTES] = '{default: `EEW_ERASED_BYTE};
  // Interrupts
  logic [`EEW_IRQ_W-1:0] irq_status_r, irq_mask_r, irq_event;
  // Bus holding registers
  logic                  aw_held_r, w_held_r, wlane0_r;
  logic [`EEW_IDX_W-1:0] aw_idx_r;
  logic [31:0]           wdata_r;
  // Decoded write
  logic        aw_take, w_take, b_done, wr_fire;
  logic        wr_ctrl, wr_array, wr_sts, wr_msk, wr_mapped;
  logic        ctrl_take, array_ok, array_wr, row_hit;
  logic        byte_launch, row_load, row_launch;
  logic        row_mode_rise, row_mode_drop, latch_clear, wr_abort;
  eew_byte_t   wr_addr, wr_byte;
  // Decoded read
  logic                  ar_take, rd_array, rd_abort;
  logic [`EEW_IDX_W-1:0] ar_idx;
  logic [31:0]           rd_data;
  logic [1:0]            rd_resp;

  // Timer that sets the length of each programming cycle
  eew_prog_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (tmr_start),
    .busy    (tmr_busy),
    .done    (tmr_done)
  );

  // Busy spans the timer run and the commit cycle after it
  assign busy = (prog_state_r != EEW_IDLE);
  // Write channel handshakes
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign b_done  = s_axi_bvalid && s_axi_bready;
  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
  // Write address decode
  assign wr_array  = wr_fire && (aw_idx_r <= `EEW_IDX_ARRAY_LAST);
  assign wr_ctrl   = wr_fire && (aw_idx_r == `EEW_IDX_CONTROL);
  assign wr_sts    = wr_fire && (aw_idx_r == `EEW_IDX_IRQ_STATUS);
  assign wr_msk    = wr_fire && (aw_idx_r == `EEW_IDX_IRQ_MASK);
  assign wr_mapped = wr_array || wr_ctrl || wr_sts || wr_msk;
  assign wr_addr   = aw_idx_r[7:0];
  assign wr_byte   = wdata_r[7:0];
  // Control writes only land while idle
  assign ctrl_take = wr_ctrl && wlane0_r && !busy;
  // Array reachable only when powered and idle
  assign array_ok = !busy && !array_standby_r;
  assign array_wr = wr_array && wlane0_r && array_ok;
  // Row match on the upper address bits once a row is latched
  assign row_hit = !row_addr_valid_r ||
                   (wr_addr[7:3] == row_addr_r);
  // Byte mode needs enable; row mode fills latches instead
  assign byte_launch = array_wr && !row_mode_enable_r &&
                       program_enable_r;
  assign row_load    = array_wr && row_mode_enable_r &&
                       !row_program_start_r && row_hit;
  // Start is taken only on already set enable and row mode
  assign row_launch = ctrl_take && wdata_r[`EEW_BIT_START] &&
                      program_enable_r && row_mode_enable_r &&
                      !array_standby_r;
  // Row mode edges seen through control writes
  assign row_mode_rise = ctrl_take && wdata_r[`EEW_BIT_ROW_MODE] &&
                         !row_mode_enable_r;
  assign row_mode_drop = ctrl_take && !wdata_r[`EEW_BIT_ROW_MODE] &&
                         row_mode_enable_r;
  assign latch_clear   = row_mode_rise || row_mode_drop ||
                         (tmr_done && prog_state_r == EEW_PROG_ROW);
  // Abort event: array touched while busy or in standby, or control busy
  assign wr_abort  = wr_array && !array_ok;
  assign irq_event[`EEW_IRQ_DONE]  = tmr_done;
  assign irq_event[`EEW_IRQ_ABORT] = wr_abort || rd_abort ||
                                     (wr_ctrl && busy);
  assign tmr_start = byte_launch || row_launch;

  // Write address holding; released once the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_held_r     <= 1'b0;
      aw_idx_r      <= '0;
    end else begin
      if (aw_take) begin
        aw_held_r     <= 1'b1;
        aw_idx_r      <= s_axi_awaddr[`EEW_ADDR_W-1:2];
        s_axi_awready <= 1'b0;
      end else if (b_done) begin
        aw_held_r     <= 1'b0;
        s_axi_awready <= 1'b1;
      end else if (!aw_held_r) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  // Write data holding; only byte lane 0 carries register bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_held_r     <= 1'b0;
      wdata_r      <= '0;
      wlane0_r     <= 1'b0;
    end else begin
      if (w_take) begin
        w_held_r     <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wlane0_r     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end else if (b_done) begin
        w_held_r     <= 1'b0;
        s_axi_wready <= 1'b1;
      end else if (!w_held_r) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response; aborted array access and holes answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `EEW_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (!wr_mapped || wr_abort) ? `EEW_RESP_SLVERR
                                               : `EEW_RESP_OKAY;
    end else if (b_done) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control bits; reserved and unused bits are not stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      array_standby_r   <= CTRL_RESET[`EEW_BIT_STANDBY];
      program_enable_r  <= CTRL_RESET[`EEW_BIT_ENABLE];
      row_mode_enable_r <= CTRL_RESET[`EEW_BIT_ROW_MODE];
    end else if (ctrl_take) begin
      array_standby_r   <= wdata_r[`EEW_BIT_STANDBY];
      program_enable_r  <= wdata_r[`EEW_BIT_ENABLE];
      row_mode_enable_r <= wdata_r[`EEW_BIT_ROW_MODE];
    end else if (tmr_done && prog_state_r == EEW_PROG_ROW) begin
      row_mode_enable_r <= 1'b0;
    end
  end

  // Start bit; a refused start leaves it clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      row_program_start_r <= CTRL_RESET[`EEW_BIT_START];
    end else if (row_launch) begin
      row_program_start_r <= 1'b1;
    end else if (tmr_done) begin
      row_program_start_r <= 1'b0;
    end
  end

  // Programming state and the byte waiting for a byte-mode cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_state_r <= EEW_IDLE;
      byte_addr_r  <= '0;
      byte_data_r  <= '0;
    end else if (byte_launch) begin
      prog_state_r <= EEW_PROG_BYTE;
      byte_addr_r  <= wr_addr;
      byte_data_r  <= wr_byte;
    end else if (row_launch) begin
      prog_state_r <= EEW_PROG_ROW;
    end else if (tmr_done) begin
      prog_state_r <= EEW_IDLE;
    end
  end

  // Row address latched by the first load, dropped with the latches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      row_addr_valid_r <= 1'b0;
      row_addr_r       <= '0;
    end else if (latch_clear) begin
      row_addr_valid_r <= 1'b0;
    end else if (row_load && !row_addr_valid_r) begin
      row_addr_valid_r <= 1'b1;
      row_addr_r       <= wr_addr[7:3];
    end
  end

  // Eight volatile row latches with their loaded flags
  for (genvar gi = 0; gi < `EEW_ROW_BYTES; gi++) begin : g_latch
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        row_loaded_r[gi] <= 1'b0;
        row_data_r[gi]   <= `EEW_LATCH_CLEAR;
      end else if (latch_clear) begin
        row_loaded_r[gi] <= 1'b0;
        row_data_r[gi]   <= `EEW_LATCH_CLEAR;
      end else if (row_load && wr_addr[2:0] == 3'(gi)) begin
        row_loaded_r[gi] <= 1'b1;
        row_data_r[gi]   <= wr_byte;
      end
    end
  end

  // Commit at the end of the cycle, so an abandoned row writes nothing
  always_ff @(posedge aclk) begin
    if (tmr_done && prog_state_r == EEW_PROG_BYTE) begin
      cells[byte_addr_r[6:0]] <= byte_data_r;
    end else if (tmr_done && prog_state_r == EEW_PROG_ROW) begin
      for (int i = 0; i < `EEW_ROW_BYTES; i++) begin
        if (row_loaded_r[i]) begin
          cells[{row_addr_r[3:0], 3'(i)}] <= row_data_r[i];
        end
      end
    end
  end

  // Read decode; busy status stays readable through the control word
  assign ar_take  = s_axi_arvalid && s_axi_arready;
  assign ar_idx   = s_axi_araddr[`EEW_ADDR_W-1:2];
  assign rd_array = ar_take && (ar_idx <= `EEW_IDX_ARRAY_LAST);
  assign rd_abort = rd_array && !array_ok;
  always_comb begin
    rd_data = '0;
    rd_resp = `EEW_RESP_OKAY;
    if (ar_idx <= `EEW_IDX_ARRAY_LAST) begin
      if (array_ok) begin
        rd_data[7:0] = cells[ar_idx[6:0]];
      end else begin
        rd_resp = `EEW_RESP_SLVERR;
      end
    end else if (ar_idx == `EEW_IDX_CONTROL) begin
      rd_data[`EEW_BIT_BUSY] = busy;
    end else if (ar_idx == `EEW_IDX_IRQ_STATUS) begin
      rd_data[`EEW_IRQ_W-1:0] = irq_status_r;
    end else if (ar_idx == `EEW_IDX_IRQ_MASK) begin
      rd_data[`EEW_IRQ_W-1:0] = irq_mask_r;
    end else begin
      rd_resp = `EEW_RESP_SLVERR;
    end
  end

  // Read channel: one read at a time, data one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `EEW_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_resp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Sticky events; a new event wins over a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_r <= `EEW_IRQ_RESET;
    end else begin
      irq_status_r <= (irq_status_r &
                       ~((wr_sts && wlane0_r) ?
                         wdata_r[`EEW_IRQ_W-1:0] : `EEW_IRQ_RESET)) |
                      irq_event;
    end
  end

  // Interrupt mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_r <= `EEW_IRQ_RESET;
    end else if (wr_msk && wlane0_r) begin
      irq_mask_r <= wdata_r[`EEW_IRQ_W-1:0];
    end
  end

  // Registered status outputs, one cycle behind their sources
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq                 <= 1'b0;
      array_low_power     <= 1'b0;
      program_in_progress <= 1'b0;
    end else begin
      irq                 <= |(irq_status_r & irq_mask_r);
      array_low_power     <= array_standby_r;
      program_in_progress <= busy || tmr_busy;
    end
  end

endmodule : eew_write_ctrl

// ---- eew_write_ctrl_properties.sv ----
// Port-level timing properties of the EEPROM write control
`timescale 1ns/100ps
`include "eew_map.svh"
module eew_write_ctrl_properties #(
  parameter int PROG_CYCLES = `EEW_PROG_CYCLES_DEF
) (
  // Clock and reset
  input wire logic                   aclk,
  input wire logic                   aresetn,
  // Write channels
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic [1:0]             s_axi_bresp,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  // Read channels
  input wire logic [`EEW_ADDR_W-1:0] s_axi_araddr,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic [31:0]            s_axi_rdata,
  input wire logic [1:0]             s_axi_rresp,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  // Status
  input wire logic                   array_low_power,
  input wire logic                   program_in_progress
);
  logic [`EEW_TMR_W-1:0] busy_len_r;
  logic                  arr_rd_r;

  // Length of the current busy stretch
  always_ff @(posedge aclk) begin
    if (!aresetn || !program_in_progress) begin
      busy_len_r <= '0;
    end else begin
      busy_len_r <= busy_len_r + 1'b1;
    end
  end

  // Array read just taken; answer shows one edge later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arr_rd_r <= 1'b0;
    end else begin
      arr_rd_r <= s_axi_arvalid && s_axi_arready &&
                  (s_axi_araddr[`EEW_ADDR_W-1:2] <= `EEW_IDX_ARRAY_LAST);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  bresp_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rdata_holds_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped");
  resp_blocks_aw_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  resp_blocks_ar_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  wresp_timing_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("late bvalid");
  rresp_timing_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("late rvalid");
  busy_length_a: assert property ($fell(program_in_progress) |->
    busy_len_r == `EEW_TMR_W'(PROG_CYCLES + 1)) else $error("busy length");
  busy_abort_a: assert property (arr_rd_r && program_in_progress |->
    s_axi_rresp == `EEW_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("array read while busy not aborted");
  standby_abort_a: assert property (arr_rd_r && array_low_power |->
    s_axi_rresp == `EEW_RESP_SLVERR) else $error("standby read answered");
  start_cause_a: assert property ($rose(program_in_progress) |->
    $past(s_axi_bvalid)) else $error("cycle without a write");
endmodule : eew_write_ctrl_properties

bind eew_write_ctrl eew_write_ctrl_properties #(
  .PROG_CYCLES(PROG_CYCLES)
) props_i (.*);

// ---- eew_cpu_model.sv ----
// AXI4-Lite master standing in for the CPU core's data accesses
`timescale 1ns/100ps
`include "eew_map.svh"
module eew_cpu_model (
  // Clock
  input wire logic                   aclk,
  // Write channels
  output logic [`EEW_ADDR_W-1:0]     s_axi_awaddr,
  output logic                       s_axi_awvalid,
  input wire logic                   s_axi_awready,
  output logic [31:0]                s_axi_wdata,
  output logic [3:0]                 s_axi_wstrb,
  output logic                       s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic [1:0]             s_axi_bresp,
  input wire logic                   s_axi_bvalid,
  output logic                       s_axi_bready,
  // Read channels
  output logic [`EEW_ADDR_W-1:0]     s_axi_araddr,
  output logic                       s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic [31:0]            s_axi_rdata,
  input wire logic [1:0]             s_axi_rresp,
  input wire logic                   s_axi_rvalid,
  output logic                       s_axi_rready
);
  // Idle bus at time zero; whole-word strobes only
  initial begin
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end

  // One write; released lines carry inverted values, never the old ones
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    output logic [1:0] resp);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~{24'h0, d};
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  // One read, held until the slave takes the address
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : eew_cpu_model

// ---- tb.sv ----
// Self-checking bench for the EEPROM write control
`timescale 1ns/100ps
`include "eew_map.svh"
module tb;
  localparam int          PC = 20;
  localparam logic [11:0] CTRL = {`EEW_IDX_CONTROL, 2'b00};
  localparam logic [11:0] STAT = {`EEW_IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] MASK = {`EEW_IDX_IRQ_MASK, 2'b00};
  localparam logic [33:0] SLV = {`EEW_RESP_SLVERR, 32'h0};

  logic                   aclk = 1'b0;
  logic                   aresetn = 1'b0;
  logic [`EEW_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]            s_axi_wdata, s_axi_rdata;
  logic [3:0]             s_axi_wstrb;
  logic [1:0]             s_axi_bresp, s_axi_rresp;
  logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                   s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                   s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic                   s_axi_rready, array_low_power;
  logic                   program_in_progress, irq;
  logic [7:0]             row_exp [8];
  int                     errors, samples_checked;

  always #2 aclk = ~aclk;

  eew_write_ctrl #(.PROG_CYCLES(PC)) uut (.*);
  eew_cpu_model cpu (.*);

  function automatic logic [11:0] ea(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction : ea

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Read; answer compared as {resp, data}
  task automatic rd(input logic [11:0] a, input logic [33:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    cpu.rd(a, d, r);
    chk({r, d}, exp);
  endtask : rd

  // Write; every write in this bench expects OKAY; reserved bits kept 0
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic [1:0] r;
    cpu.wr(a, v, r);
    chk({32'h0, r}, {32'h0, `EEW_RESP_OKAY});
  endtask : wr

  // Poll busy clear before touching the array again
  task automatic idle;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    n = 0;
    do begin
      cpu.rd(CTRL, d, r);
      n++;
    end while (d[`EEW_BIT_BUSY] !== 1'b0 && n < 100);
    chk({33'h0, d[`EEW_BIT_BUSY]}, 34'h0);
  endtask : idle

  task test_done;
    $display("Checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    test_done;
  end

  initial begin
    errors = 0;
    samples_checked = 0;
    row_exp = '{8'h11, 8'hFF, 8'h22, 8'h33, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTRL, 34'h0);
    rd(STAT, 34'h0);
    rd(12'h200, SLV);
    // Byte write with programming disabled
    wr(ea(8'h05), 8'h12);
    rd(CTRL, 34'h0);
    rd(ea(8'h05), 34'h0FF);
    // Byte write, then accesses while busy
    wr(CTRL, 8'h01);
    wr(ea(8'h05), 8'hA5);
    rd(ea(8'h05), SLV);
    rd(CTRL, 34'h2);
    chk({33'h0, program_in_progress}, 34'h1);
    wr(CTRL, 8'h41);
    idle;
    chk({33'h0, array_low_power}, 34'h0);
    rd(ea(8'h05), 34'h0A5);
    // Partial row write, one stray byte to another row
    wr(CTRL, 8'h05);
    wr(ea(8'h18), 8'h11);
    wr(ea(8'h1A), 8'h22);
    wr(ea(8'h1B), 8'h33);
    wr(ea(8'h20), 8'h44);
    wr(CTRL, 8'h0D);
    idle;
    for (int i = 0; i < 8; i++) begin
      rd(ea(8'h18 + 8'(i)), {26'h0, row_exp[i]});
    end
    rd(ea(8'h20), 34'h0FF);
    // Row mode gone: a plain write programs one byte
    wr(ea(8'h30), 8'h77);
    idle;
    rd(ea(8'h30), 34'h077);
    wr(CTRL, 8'h09);
    rd(CTRL, 34'h0);
    // Loaded row dropped, then a fresh row started
    wr(CTRL, 8'h05);
    wr(ea(8'h40), 8'h99);
    wr(CTRL, 8'h01);
    rd(ea(8'h40), 34'h0FF);
    wr(CTRL, 8'h05);
    wr(ea(8'h41), 8'h66);
    wr(CTRL, 8'h0D);
    idle;
    rd(ea(8'h40), 34'h0FF);
    rd(ea(8'h41), 34'h066);
    // Standby blocks the array
    wr(CTRL, 8'h41);
    repeat (2) @(posedge aclk);
    chk({33'h0, array_low_power}, 34'h1);
    rd(ea(8'h05), SLV);
    wr(CTRL, 8'h01);
    repeat (2) @(posedge aclk);
    chk({33'h0, array_low_power}, 34'h0);
    // Interrupt: both events pending, masked, unmasked, cleared
    rd(STAT, 34'h3);
    chk({33'h0, irq}, 34'h0);
    wr(MASK, 8'h03);
    repeat (2) @(posedge aclk);
    chk({33'h0, irq}, 34'h1);
    wr(STAT, 8'h03);
    repeat (2) @(posedge aclk);
    chk({33'h0, irq}, 34'h0);
    rd(STAT, 34'h0);
    rd(MASK, 34'h3);
    test_done;
  end
endmodule : tb
